// >>> hdl/uart_brk.sv
/*
 * Serial port: async transmit with break, async receive with wake-on-break,
 * synchronous host transmit on the data and clock lines, AHB-Lite registers.
 * Assumes the data line input comes from a pin and is synchronised here.
 */
// Behaviour
// - nonzero character: first low interval is wake
// - wake event sets the receive flag
// - line rising edge clears wake enable
// - receive data read clears the flag
// - receiver stays idle while wake enabled
// - break is start, twelve zeros, stop
// - write with break enabled sends zeros
// - send break clears after stop; buffer follows
// - shift empty status same as normal characters
// - header is break then sync byte
// - buffer empty flag means next write allowed
// - received break: flag, framing error, zero
// - wake watches two transitions, then next byte
// - sync mode: half duplex, no framing bits
// - host mode select; receive enables pick direction
// - host drives and enables clock pin
// - one clock per bit, change leading edge
// - polarity sets clock idle level and edge
// - write waits for shifter, else starts now
// - host transmit enables data and clock drivers
// - wake is falling edge, async mode only
`timescale 1ns/1ns
module uart_brk (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Data line: receive in, synchronous transmit out.
	input wire logic sync_data_line,
	output logic sync_data_drive,
	output logic sync_data_oe,
	// Clock line: async transmit or host bit clock.
	output logic sync_clock_drive,
	output logic sync_clock_oe
);
	import uart_brk_pkg::*;

	typedef struct packed {
		ctrl_s ctrl;
		logic [15:0] baud;
		logic [7:0] txbuf;
		logic txbuf_full;
		tx_state_e txs;
		logic [8:0] transmit_shifter;
		logic [3:0] tbits;
		logic half;
		logic brk;
		rx_state_e rxs;
		logic [7:0] rsr;
		logic [2:0] rbits;
		logic rhalf;
		logic rx_prev;
		logic [7:0] rxd;
		logic rflag;
		logic framing_error_flag;
		logic wake_low;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic rdy;
		logic resp;
		logic [31:0] rdata;
		logic ck;
		logic ck_oe;
		logic dt;
		logic dt_oe;
	} st_s;

	st_s q;
	st_s d;
	logic rx;
	logic ttick;
	logic rtick;
	logic trestart;
	logic rrestart;
	logic sync_host;
	logic host_rx;
	logic tx_ok;
	logic load;
	logic rd_rx;
	logic set_flag;
	logic fall;
	logic rise;
	logic wake_armed;

	////////////////////////////////////////////////////////////////////////
	// Input synchroniser and the two baud generators.
	two_flop_sync #(.W(1)) u_rx_sync (
		.clk(clk),
		.arst_n(arst_n),
		.async_level(sync_data_line),
		.sync_level(rx)
	);

	baud_tick #(.W(16)) u_tx_baud (
		.clk(clk),
		.arst_n(arst_n),
		.restart(trestart),
		.div(q.baud),
		.tick(ttick)
	);

	baud_tick #(.W(16)) u_rx_baud (
		.clk(clk),
		.arst_n(arst_n),
		.restart(rrestart),
		.div(q.baud),
		.tick(rtick)
	);

	////////////////////////////////////////////////////////////////////////
	// Mode decode.
	always_comb begin
		sync_host = q.ctrl.port_enable & q.ctrl.sync_select & q.ctrl.clock_source_select;
		host_rx = sync_host & (q.ctrl.single_receive_enable | q.ctrl.continuous_receive_enable);
		tx_ok = q.ctrl.port_enable & q.ctrl.transmit_enable & ~host_rx;
		load = (q.txs == TX_IDLE) & q.txbuf_full & tx_ok;
		fall = q.rx_prev & ~rx;
		rise = ~q.rx_prev & rx;
		wake_armed = q.ctrl.wake_on_break_enable & q.ctrl.port_enable & ~q.ctrl.sync_select;
		rd_rx = hsel & htrans[1] & hready & ~hwrite & (haddr[7:0] == A_RXD);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		d = q;
		trestart = 1'b0;
		rrestart = 1'b0;
		set_flag = 1'b0;
		d.rdy = 1'b1;
		d.resp = 1'b0;
		d.rx_prev = rx;
		d.wr_pend = 1'b0;

		// Bus data phase of a write.
		if (q.wr_pend) begin
			case (q.wr_addr)
				A_CTRL: d.ctrl = hwdata[10:0];
				A_TXD: begin
					if (!q.txbuf_full) begin
						d.txbuf = hwdata[7:0];
						d.txbuf_full = 1'b1;
					end
				end
				A_BAUD: d.baud = hwdata[15:0];
				default: d.wr_pend = 1'b0;
			endcase
		end

		// Bus address phase.
		if (hsel && htrans[1] && hready) begin
			d.wr_pend = hwrite;
			d.wr_addr = haddr[7:0];
			d.rdata = 32'h0000_0000;
			if (!hwrite) begin
				case (haddr[7:0])
					A_CTRL: d.rdata = {21'h0, q.ctrl};
					A_STAT: begin
						d.rdata[ST_SHIFT_EMPTY] = (q.txs == TX_IDLE);
						d.rdata[ST_TX_EMPTY] = ~q.txbuf_full;
						d.rdata[ST_RX_FLAG] = q.rflag;
						d.rdata[ST_FRAME_ERR] = q.framing_error_flag;
						d.rdata[ST_RX_IDLE] = (q.rxs == RX_IDLE);
					end
					A_RXD: d.rdata = {24'h000000, q.rxd};
					A_BAUD: d.rdata = {16'h0000, q.baud};
					default: d.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Transmitter.
		if (load) begin
			d.txbuf_full = 1'b0;
			d.brk = q.ctrl.send_break & ~q.ctrl.sync_select;
			d.half = 1'b0;
			trestart = 1'b1;
			if (q.ctrl.send_break && !q.ctrl.sync_select) begin
				d.transmit_shifter = 9'h000;
				d.tbits = BRK_ZEROS;
			end else begin
				d.transmit_shifter = {q.ctrl.ninth_transmit_bit, q.txbuf};
				d.tbits = q.ctrl.ninth_bit_transmit_enable ? NINE_BITS : DATA_BITS;
			end
			if (q.ctrl.sync_select) begin
				d.txs = TX_DATA;
				d.dt = q.txbuf[0];
				d.ck = ~q.ctrl.clock_polarity_select;
			end else begin
				d.txs = TX_START;
				d.ck = 1'b0;
			end
		end else if (q.txs == TX_IDLE) begin
			d.ck = sync_host ? q.ctrl.clock_polarity_select : 1'b1;
		end else if (ttick) begin
			d.half = ~q.half;
			if (q.ctrl.sync_select && !q.half) begin
				d.ck = q.ctrl.clock_polarity_select;
			end else if (q.half) begin
				case (q.txs)
					TX_START: begin
						d.txs = TX_DATA;
						d.ck = q.transmit_shifter[0];
					end
					TX_DATA: begin
						d.transmit_shifter = q.transmit_shifter >> 1;
						d.tbits = q.tbits - 1'b1;
						if (q.tbits == 4'h1) begin
							d.txs = q.ctrl.sync_select ? TX_IDLE : TX_STOP;
							d.ck = ~q.ctrl.sync_select | q.ctrl.clock_polarity_select;
						end else if (q.ctrl.sync_select) begin
							d.ck = ~q.ctrl.clock_polarity_select;
							d.dt = q.transmit_shifter[1];
						end else begin
							d.ck = q.transmit_shifter[1];
						end
					end
					TX_STOP: begin
						d.txs = TX_IDLE;
						if (q.brk) begin
							d.ctrl.send_break = 1'b0;
						end
					end
					default: d.txs = TX_IDLE;
				endcase
			end
		end

		// Receiver.
		if (wake_armed) begin
			d.rxs = RX_IDLE;
			if (fall) begin
				set_flag = 1'b1;
				d.wake_low = 1'b1;
			end else if (rise && q.wake_low) begin
				d.ctrl.wake_on_break_enable = 1'b0;
				d.wake_low = 1'b0;
			end
		end else begin
			d.wake_low = 1'b0;
			case (q.rxs)
				RX_IDLE: begin
					if (fall && q.ctrl.continuous_receive_enable && !q.ctrl.sync_select) begin
						d.rxs = RX_START;
						rrestart = 1'b1;
					end
				end
				RX_START: begin
					if (rtick) begin
						d.rxs = rx ? RX_IDLE : RX_DATA;
						d.rhalf = 1'b0;
						d.rbits = 3'h0;
					end
				end
				RX_DATA: begin
					if (rtick) begin
						d.rhalf = ~q.rhalf;
						if (q.rhalf) begin
							d.rsr = {rx, q.rsr[7:1]};
							d.rbits = q.rbits + 1'b1;
							if (q.rbits == RX_LAST) begin
								d.rxs = RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (rtick) begin
						d.rhalf = ~q.rhalf;
						if (q.rhalf) begin
							d.rxs = RX_IDLE;
							d.rxd = q.rsr;
							d.framing_error_flag = ~rx;
							set_flag = 1'b1;
						end
					end
				end
				default: d.rxs = RX_IDLE;
			endcase
		end
		d.rflag = (q.rflag & ~rd_rx) | set_flag;

		// Pin drivers.
		d.ck_oe = q.ctrl.port_enable & (sync_host | ~q.ctrl.sync_select);
		d.dt_oe = sync_host & ~host_rx;

		if (!q.ctrl.port_enable) begin
			d.txs = TX_IDLE;
			d.rxs = RX_IDLE;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.baud <= BAUD_RST;
			q.rx_prev <= 1'b1;
			q.ck <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign hreadyout = q.rdy;
	assign hresp = q.resp;
	assign hrdata = q.rdata;
	assign sync_data_drive = q.dt;
	assign sync_data_oe = q.dt_oe;
	assign sync_clock_drive = q.ck;
	assign sync_clock_oe = q.ck_oe;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	chk_wake_flag: assert property (wake_armed && fall |=> q.rflag && q.wake_low)
		else $error("Wake edge did not raise the receive flag.");
	chk_wake_clear: assert property (wake_armed && rise && q.wake_low
		|=> !q.ctrl.wake_on_break_enable)
		else $error("Wake enable not cleared on rising edge.");
	chk_read_clear: assert property (rd_rx && !set_flag |=> !q.rflag)
		else $error("Receive data read did not clear the flag.");
	chk_wake_idle: assert property (wake_armed |=> q.rxs == RX_IDLE)
		else $error("Receiver left idle while wake enabled.");
	chk_break_zero: assert property (load && q.ctrl.send_break && !q.ctrl.sync_select
		|=> q.transmit_shifter == 9'h000 && q.tbits == BRK_ZEROS && q.txs == TX_START)
		else $error("Break character not loaded as twelve zeros.");
	chk_break_end: assert property (q.txs == TX_STOP && ttick && q.half && q.brk
		|=> !q.ctrl.send_break && q.txs == TX_IDLE)
		else $error("Send break not cleared after the stop bit.");
	chk_buf_free: assert property (load |=> !q.txbuf_full && q.txs != TX_IDLE)
		else $error("Buffer not freed when shifter loaded.");
	chk_host_oe: assert property (sync_host && !host_rx |=> q.dt_oe && q.ck_oe)
		else $error("Host transmit drivers not enabled.");
	chk_clk_idle: assert property (sync_host && q.txs == TX_IDLE && !load
		|=> q.ck == $past(q.ctrl.clock_polarity_select))
		else $error("Host clock not at its idle level.");
	chk_rx_done: assert property (q.rxs == RX_STOP && rtick && q.rhalf && !wake_armed
		|=> q.rflag && q.rxd == $past(q.rsr) && q.framing_error_flag == !$past(rx))
		else $error("Received character not delivered with framing status.");
endmodule

// >>> hdl/uart_brk_pkg.sv
/*
 * Shared constants, register map and carrier types of the serial port with
 * break, wake-on-break and synchronous host transmit.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package uart_brk_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TXD = 8'h08;
	localparam logic [7:0] A_RXD = 8'h0C;
	localparam logic [7:0] A_BAUD = 8'h10;

	// Status bit positions.
	localparam int ST_SHIFT_EMPTY = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_RX_FLAG = 2;
	localparam int ST_FRAME_ERR = 3;
	localparam int ST_RX_IDLE = 4;

	// Values after reset and bit counts.
	localparam logic [15:0] BAUD_RST = 16'h0010;
	localparam logic [3:0] BRK_ZEROS = 4'hC;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [3:0] NINE_BITS = 4'h9;
	localparam logic [2:0] RX_LAST = 3'h7;

	////////////////////////////////////////////////////////////////////////
	// Control register, bit 0 first from the bottom.
	typedef struct packed {
		logic ninth_transmit_bit;
		logic ninth_bit_transmit_enable;
		logic wake_on_break_enable;
		logic clock_polarity_select;
		logic continuous_receive_enable;
		logic single_receive_enable;
		logic send_break;
		logic transmit_enable;
		logic clock_source_select;
		logic sync_select;
		logic port_enable;
	} ctrl_s;

	localparam ctrl_s CTRL_RST = 11'h0;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_START = 2'h1,
		TX_DATA = 2'h3,
		TX_STOP = 2'h2
	} tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'h0,
		RX_START = 2'h1,
		RX_DATA = 2'h3,
		RX_STOP = 2'h2
	} rx_state_e;

endpackage

// >>> hdl/two_flop_sync.sv
/*
 * Two-flop synchroniser for levels entering the clk domain.
 * Assumes the input is a level that stays for at least two clk periods.
 * Resets to all ones, the idle level of a serial line, so no false edge follows reset.
 */
`timescale 1ns/1ns
module two_flop_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Level in and out.
	input wire logic [W-1:0] async_level,
	output logic [W-1:0] sync_level
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} st_s;

	st_s q;
	st_s d;

	always_comb begin
		d.meta = async_level;
		d.stable = q.meta;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign sync_level = q.stable;
endmodule

// >>> hdl/baud_tick.sv
/*
 * Baud-rate generator: one-cycle tick every div+1 clocks, restartable.
 * Assumes div is held stable by software while a character is in flight.
 */
`timescale 1ns/1ns
module baud_tick #(
	parameter int W = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Control.
	input wire logic restart,
	input wire logic [W-1:0] div,
	// Enable pulse.
	output logic tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} st_s;

	st_s q;
	st_s d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (restart) begin
			d.cnt = div;
		end else if (q.cnt == '0) begin
			d.cnt = div;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule

// >>> test/serial_node.sv
/*
 * Remote serial node: async sender and frame decoder, sync client on the clock line.
 * Assumes the bench clock and a bit time of BIT clocks; the line idles high.
 */
`timescale 1ns/1ns
module serial_node #(
	parameter int BIT = 16
) (
	// Clock.
	input wire logic clk,
	// Lines.
	input wire logic ck_line,
	input wire logic dt_line,
	input wire logic pol,
	output logic rx_line
);
	logic [7:0] b0, b1, sh;
	logic [15:0] sw;
	logic ckp;
	int nb, sc, low, long_low, per, tl, tt;
	initial begin
		rx_line = 1'b1;
		nb = 0;
		sc = 0;
		low = 0;
		long_low = 0;
		tl = 0;
		tt = 0;
		ckp = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// Sends n bits LSB first, then one stop bit.
	task send(input logic [15:0] v, input int n);
		for (int i = 0; i <= n; i++) begin
			rx_line <= (i < n) ? v[i] : 1'b1;
			repeat (BIT) @(posedge clk);
		end
	endtask
	// Decodes async frames at bit centres.
	always begin
		@(negedge ck_line);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			sh[i] = ck_line;
		end
		b1 = b0;
		b0 = sh;
		nb++;
		repeat (BIT) @(posedge clk);
		wait (ck_line === 1'b1);
	end
	// Measures long low runs and samples data on trailing clock edges.
	always @(posedge clk) begin
		low <= ck_line ? 0 : low + 1;
		if (ck_line && low > 4 * BIT)
			long_low <= low;
		ckp <= ck_line;
		tl <= tl + 1;
		if (ckp !== ck_line && ck_line === pol) begin
			sw <= {dt_line, sw[15:1]};
			sc <= sc + 1;
			per <= tl - tt;
			tt <= tl;
		end
	end
endmodule

// >>> test/uart_brk_tb.sv
/*
 * Self-checking bench of the serial port with break, wake and sync host transmit.
 * Assumes the remote node model on the pins and BAUD set to 7 (16-clock bits).
 */
`timescale 1ns/1ns
module uart_brk_tb;
	import uart_brk_pkg::*;
	localparam int BIT = 16;
	logic clk, arst_n, hsel, hwrite, hreadyout, hresp, pol;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic dt_drive, dt_oe, ck_drive, ck_oe, node_rx, dt_wire;
	int errors, checked;
	assign dt_wire = dt_oe ? dt_drive : node_rx;
	uart_brk u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sync_data_line(dt_wire),
		.sync_data_drive(dt_drive), .sync_data_oe(dt_oe), .sync_clock_drive(ck_drive),
		.sync_clock_oe(ck_oe));
	serial_node #(.BIT(BIT)) u_node (.clk(clk), .ck_line(ck_drive), .dt_line(dt_drive),
		.pol(pol), .rx_line(node_rx));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			errors++;
			stop_test();
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, e, q);
	endtask
	task wait_for(input int s, input int t);
		int n;
		n = 0;
		while ((s ? u_node.sc : u_node.nb) < t && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) begin
			errors++;
			stop_test();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdc("ctrl", A_CTRL, 32'h0);
		rdc("baud", A_BAUD, 32'h10);
		rd(A_STAT);
		chk("stat", 32'h3, q & 32'h3);
		rdc("unmapped", 8'h14, 32'h0);
		wr(A_BAUD, 32'h7);
		rdc("baud", A_BAUD, 32'h7);
		$display("test reset done");
	endtask
	task t_break;
		int n;
		n = u_node.nb;
		wr(A_CTRL, 32'h19);
		wr(A_TXD, 32'hFF);
		wr(A_TXD, 32'h55);
		rd(A_STAT);
		chk("shift busy", 32'h0, q & 32'h1);
		chk("buffer full", 32'h0, q & 32'h2);
		wr(A_TXD, 32'hAA);
		wait_for(0, n + 2);
		chk("break bits", 32'hD, (u_node.long_low + BIT / 2) / BIT);
		chk("break data", 32'h0, {24'h0, u_node.b1});
		chk("sync byte", 32'h55, {24'h0, u_node.b0});
		rdc("ctrl", A_CTRL, 32'h9);
		cyc(2 * BIT);
		rd(A_STAT);
		chk("tx idle", 32'h3, q & 32'h3);
		$display("test break done");
	endtask
	task t_wake;
		rd(A_STAT);
		chk("rx idle", 32'h10, q & 32'h10);
		wr(A_CTRL, 32'h141);
		fork
			u_node.send(16'h0, 13);
			begin
				cyc(4 * BIT);
				rd(A_STAT);
				chk("wake flag", 32'h4, q & 32'hC);
				rdc("wake held", A_CTRL, 32'h141);
			end
		join
		rdc("wake clear", A_CTRL, 32'h41);
		rd(A_RXD);
		rd(A_STAT);
		chk("flag clear", 32'h0, q & 32'h4);
		u_node.send({7'h0, 8'h3C, 1'b0}, 9);
		rd(A_STAT);
		chk("second flag", 32'h4, q & 32'hC);
		rdc("next byte", A_RXD, 32'h3C);
		$display("test wake done");
	endtask
	task t_rxbrk;
		u_node.send(16'h0, 13);
		rd(A_STAT);
		chk("break flags", 32'hC, q & 32'hC);
		rdc("break byte", A_RXD, 32'h0);
		rd(A_STAT);
		chk("flag clear", 32'h0, q & 32'h4);
		$display("test receive break done");
	endtask
	task t_sync(input logic p);
		int n;
		pol <= p;
		wr(A_CTRL, {24'h0, p, 7'h2F});
		cyc(2);
		chk("rx dt oe", 32'h0, {31'h0, dt_oe});
		chk("rx ck oe", 32'h1, {31'h0, ck_oe});
		wr(A_CTRL, {24'h0, p, 7'h0F});
		cyc(2);
		chk("dt oe", 32'h1, {31'h0, dt_oe});
		chk("ck oe", 32'h1, {31'h0, ck_oe});
		chk("ck idle", {31'h0, p}, {31'h0, ck_drive});
		n = u_node.sc;
		wr(A_TXD, 32'hC3);
		wr(A_TXD, 32'h5A);
		wait_for(1, n + 16);
		cyc(2 * BIT);
		chk("sync data", 32'h5AC3, {16'h0, u_node.sw});
		chk("clocks", n + 16, u_node.sc);
		chk("bit period", BIT, u_node.per);
		chk("ck end", {31'h0, p}, {31'h0, ck_drive});
		wr(A_CTRL, {21'h0, 2'h3, 1'b0, p, 7'h0F});
		n = u_node.sc;
		wr(A_TXD, 32'h01);
		wait_for(1, n + 9);
		cyc(2 * BIT);
		chk("ninth bit", 32'h101, {23'h0, u_node.sw[15:7]});
		chk("ninth clocks", n + 9, u_node.sc);
		$display("test sync done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pol = 1'b0;
		errors = 0;
		checked = 0;
		cyc(16);
		arst_n <= 1'b1;
		cyc(2);
		t_reset();
		t_break();
		t_wake();
		t_rxbrk();
		t_sync(1'b0);
		t_sync(1'b1);
		stop_test();
	end
endmodule
